// >>> verilog/prb_pkg.sv
// Shared field layout, limits and states for the request object builder
package prb_pkg;
   localparam int PRB_W = 32;
   localparam int PRB_FW = 10;
   localparam int PRB_PW = 3;
   localparam int PRB_MAXOBJ = 7;
   // Request object field positions
   localparam int PRB_RSV_HI = 31;
   localparam int PRB_POS_HI = 30;
   localparam int PRB_POS_LO = 28;
   localparam int PRB_GB_BIT = 27;
   localparam int PRB_MIS_BIT = 26;
   localparam int PRB_COMM_BIT = 25;
   localparam int PRB_NOSUS_BIT = 24;
   localparam int PRB_RSV_LO_HI = 23;
   localparam int PRB_RSV_LO_LO = 20;
   localparam int PRB_OP_HI = 19;
   localparam int PRB_OP_LO = 10;
   localparam int PRB_LIM_HI = 9;
   localparam int PRB_LIM_LO = 0;
   // Offered object type field and battery code
   localparam int PRB_TYP_HI = 31;
   localparam int PRB_TYP_LO = 30;
   localparam logic [1:0] PRB_TYP_BATT = 2'h1;
   localparam logic [PRB_PW-1:0] PRB_POS_FIRST = 3'h1;
   localparam logic [PRB_PW-1:0] PRB_POS_NONE = 3'h0;
   localparam logic [PRB_W-1:0] PRB_RDO_RST = 32'h0000_0000;
   localparam logic [PRB_FW-1:0] PRB_F_ZERO = 10'h000;

   typedef enum logic [1:0] {PRB_IDLE, PRB_BUILD, PRB_SEND} prb_state_t;

   // Error bits of a received request object, zero when valid
   function automatic logic [4:0] prb_rdo_bad(
      input logic [PRB_W-1:0] rdo,
      input logic [PRB_PW-1:0] count,
      input logic [PRB_FW-1:0] offer);
      logic [PRB_PW-1:0] pos;
      logic [PRB_FW-1:0] op;
      logic [PRB_FW-1:0] lim;
      logic gb;
      logic mis;
      pos = rdo[PRB_POS_HI:PRB_POS_LO];
      op = rdo[PRB_OP_HI:PRB_OP_LO];
      lim = rdo[PRB_LIM_HI:PRB_LIM_LO];
      gb = rdo[PRB_GB_BIT];
      mis = rdo[PRB_MIS_BIT];
      prb_rdo_bad[0] = rdo[PRB_RSV_HI]
         | (|rdo[PRB_RSV_LO_HI:PRB_RSV_LO_LO]);
      prb_rdo_bad[1] = (pos == PRB_POS_NONE) || (pos > count);
      prb_rdo_bad[2] = op > offer;
      prb_rdo_bad[3] = !gb && ((!mis && lim > offer) || op > lim);
      prb_rdo_bad[4] = gb && (lim > op);
   endfunction
endpackage

// >>> verilog/prb_if.sv
// Link between the sink end and the source end of a power negotiation
`timescale 1ns/1ns
interface prb_if;
   import prb_pkg::*;
   logic pdo_valid;
   logic [PRB_W-1:0] pdo_data;
   logic pdo_last;
   logic rdo_valid;
   logic [PRB_W-1:0] rdo_data;
   logic rdo_ready;
   logic goto_min;
   modport sink_mp (
      input pdo_valid, pdo_data, pdo_last, rdo_ready, goto_min,
      output rdo_valid, rdo_data);
   modport source_mp (
      output pdo_valid, pdo_data, pdo_last, rdo_ready, goto_min,
      input rdo_valid, rdo_data);
endinterface

// >>> verilog/prb_sink.sv
// Sink end: keeps the offered objects and builds request objects
`timescale 1ns/1ns
module prb_sink
   import prb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   prb_if.sink_mp link,
   input wire logic [PRB_PW-1:0] req_pos,
   input wire logic req_giveback,
   input wire logic [PRB_FW-1:0] req_op,
   input wire logic [PRB_FW-1:0] req_lim,
   input wire logic need_unmet,
   input wire logic usb_comm_ok,
   input wire logic no_usb_suspend,
   input wire logic need_changed,
   output logic [PRB_W-1:0] rdo_sent,
   output logic req_battery,
   output logic caps_held,
   output logic busy,
   output logic at_min,
   output logic [PRB_FW-1:0] min_load
);
   prb_state_t state_r;
   logic [PRB_W-1:0] caps_r [PRB_MAXOBJ];
   logic [PRB_PW-1:0] wr_idx_r;
   logic [PRB_PW-1:0] count_r;
   logic caps_ok_r;
   logic pend_r;
   logic [PRB_W-1:0] rdo_r;
   logic batt_r;
   logic gb_live_r;
   logic at_min_r;
   logic [PRB_FW-1:0] min_r;
   logic caps_end;
   logic pos_ok;
   logic [PRB_PW-1:0] pos;
   logic [PRB_PW-1:0] idx;
   logic [PRB_FW-1:0] offer;
   logic [PRB_FW-1:0] op;
   logic [PRB_FW-1:0] lim;
   logic mis;
   logic [PRB_W-1:0] rdo_nxt;

   assign caps_end = link.pdo_valid && link.pdo_last;

   // Store each offered object; extras past the table are dropped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PRB_MAXOBJ; i++) begin
            caps_r[i] <= PRB_RDO_RST;
         end
         wr_idx_r <= PRB_POS_NONE;
      end else if (clk_en && link.pdo_valid) begin
         if (wr_idx_r < PRB_PW'(PRB_MAXOBJ)) begin
            caps_r[wr_idx_r] <= link.pdo_data;
         end
         if (link.pdo_last) begin
            wr_idx_r <= PRB_POS_NONE;
         end else if (wr_idx_r < PRB_PW'(PRB_MAXOBJ)) begin
            wr_idx_r <= wr_idx_r + PRB_POS_FIRST;
         end
      end
   end

   // Object count of the most recent complete offer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= PRB_POS_NONE;
         caps_ok_r <= 1'b0;
      end else if (clk_en && caps_end) begin
         count_r <= (wr_idx_r < PRB_PW'(PRB_MAXOBJ))
            ? wr_idx_r + PRB_POS_FIRST : wr_idx_r;
         caps_ok_r <= 1'b1;
      end
   end

   // A new offer or a changed need calls for a fresh request;
   // the set wins over the clear taken when the build starts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (clk_en) begin
         if (caps_end || need_changed) begin
            pend_r <= 1'b1;
         end else if (state_r == PRB_BUILD) begin
            pend_r <= 1'b0;
         end
      end
   end

   // Pick the offer; an absent one falls back to the first (5V)
   always_comb begin
      pos_ok = (req_pos != PRB_POS_NONE) && (req_pos <= count_r);
      pos = pos_ok ? req_pos : PRB_POS_FIRST;
      idx = pos - PRB_POS_FIRST;
      offer = caps_r[idx][PRB_LIM_HI:PRB_LIM_LO];
   end

   // Clamp fields so the object stays valid even when needs go unmet
   always_comb begin
      op = (req_op > offer) ? offer : req_op;
      if (req_giveback) begin
         lim = (req_lim > op) ? op : req_lim;
      end else begin
         lim = (req_lim < op) ? op : req_lim;
      end
      // Maximum above the offer is kept but must carry the mismatch
      mis = need_unmet || !pos_ok || (req_op > offer)
         || (!req_giveback && lim > offer);
      rdo_nxt = PRB_RDO_RST;
      rdo_nxt[PRB_POS_HI:PRB_POS_LO] = pos;
      rdo_nxt[PRB_GB_BIT] = req_giveback;
      rdo_nxt[PRB_MIS_BIT] = mis;
      rdo_nxt[PRB_COMM_BIT] = usb_comm_ok;
      rdo_nxt[PRB_NOSUS_BIT] = no_usb_suspend;
      // Same bits carry 10mA or 250mW units by offer type
      rdo_nxt[PRB_OP_HI:PRB_OP_LO] = op;
      rdo_nxt[PRB_LIM_HI:PRB_LIM_LO] = lim;
   end

   // Request sequencing; a new offer mid-send restarts the request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= PRB_IDLE;
      end else if (clk_en) begin
         case (state_r)
            PRB_IDLE: begin
               if (caps_ok_r && pend_r && !link.pdo_valid) begin
                  state_r <= PRB_BUILD;
               end
            end
            PRB_BUILD: begin
               state_r <= PRB_SEND;
            end
            PRB_SEND: begin
               if (link.pdo_valid) begin
                  state_r <= PRB_IDLE;
               end else if (link.rdo_ready) begin
                  state_r <= PRB_IDLE;
               end
            end
            default: begin
               state_r <= PRB_IDLE;
            end
         endcase
      end
   end

   // Latch the built object and its form
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdo_r <= PRB_RDO_RST;
         batt_r <= 1'b0;
      end else if (clk_en && state_r == PRB_BUILD) begin
         rdo_r <= rdo_nxt;
         batt_r <= caps_r[idx][PRB_TYP_HI:PRB_TYP_LO] == PRB_TYP_BATT;
      end
   end

   // GotoMin only binds once a GiveBack request was accepted
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gb_live_r <= 1'b0;
         at_min_r <= 1'b0;
         min_r <= PRB_F_ZERO;
      end else if (clk_en) begin
         if (state_r == PRB_SEND && link.rdo_ready && !link.pdo_valid)
         begin
            gb_live_r <= rdo_r[PRB_GB_BIT];
            min_r <= rdo_r[PRB_LIM_HI:PRB_LIM_LO];
            // A GotoMin in the same cycle still wins over the clear
            at_min_r <= link.goto_min && gb_live_r;
         end else if (link.goto_min && gb_live_r) begin
            at_min_r <= 1'b1;
         end
      end
   end

   assign link.rdo_valid = (state_r == PRB_SEND);
   assign link.rdo_data = rdo_r;
   assign rdo_sent = rdo_r;
   assign req_battery = batt_r;
   assign caps_held = caps_ok_r;
   assign busy = (state_r != PRB_IDLE);
   assign at_min = at_min_r;
   assign min_load = min_r;
endmodule

// >>> verilog/prb_source.sv
// Source end: sends its offer table and checks returned requests
`timescale 1ns/1ns
module prb_source
   import prb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   prb_if.source_mp link,
   input wire logic tab_wr,
   input wire logic [PRB_PW-1:0] tab_idx,
   input wire logic [PRB_W-1:0] tab_data,
   input wire logic [PRB_PW-1:0] tab_count,
   input wire logic send_caps,
   input wire logic goto_min_req,
   output logic [PRB_W-1:0] rdo_got,
   output logic req_ok,
   output logic req_bad,
   output logic [4:0] bad_why,
   output logic keep_in_suspend
);
   logic [PRB_W-1:0] tab_r [PRB_MAXOBJ];
   logic [PRB_PW-1:0] cnt_r;
   logic [PRB_PW-1:0] tx_idx_r;
   logic sending_r;
   logic [PRB_W-1:0] got_r;
   logic ok_r;
   logic bad_r;
   logic [4:0] why_r;
   logic keep_r;
   logic [PRB_PW-1:0] pos;
   logic [PRB_PW-1:0] lidx;
   logic [PRB_FW-1:0] offer;
   logic [4:0] why;

   // Offer table written by local policy
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PRB_MAXOBJ; i++) begin
            tab_r[i] <= PRB_RDO_RST;
         end
      end else if (clk_en && tab_wr && tab_idx < PRB_PW'(PRB_MAXOBJ)) begin
         tab_r[tab_idx] <= tab_data;
      end
   end

   // Stream the offer, one object a cycle, count latched at start
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sending_r <= 1'b0;
         tx_idx_r <= PRB_POS_NONE;
         cnt_r <= PRB_POS_NONE;
      end else if (clk_en) begin
         if (!sending_r && send_caps && tab_count != PRB_POS_NONE) begin
            sending_r <= 1'b1;
            tx_idx_r <= PRB_POS_NONE;
            cnt_r <= tab_count;
         end else if (sending_r) begin
            if (tx_idx_r + PRB_POS_FIRST == cnt_r) begin
               sending_r <= 1'b0;
            end
            tx_idx_r <= tx_idx_r + PRB_POS_FIRST;
         end
      end
   end

   assign link.pdo_valid = sending_r;
   // Index runs one past the table after a full offer; show zero then
   assign link.pdo_data = (tx_idx_r < PRB_PW'(PRB_MAXOBJ))
      ? tab_r[tx_idx_r] : PRB_RDO_RST;
   assign link.pdo_last = sending_r && (tx_idx_r + PRB_POS_FIRST == cnt_r);
   assign link.rdo_ready = link.rdo_valid && !sending_r;
   assign link.goto_min = goto_min_req && clk_en;

   // Look up the referenced offer and check the object against it
   always_comb begin
      pos = link.rdo_data[PRB_POS_HI:PRB_POS_LO];
      lidx = (pos == PRB_POS_NONE) ? PRB_POS_NONE : pos - PRB_POS_FIRST;
      offer = tab_r[lidx][PRB_LIM_HI:PRB_LIM_LO];
      why = prb_rdo_bad(link.rdo_data, cnt_r, offer);
   end

   // Verdict pulses and the last taken object
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         got_r <= PRB_RDO_RST;
         ok_r <= 1'b0;
         bad_r <= 1'b0;
         why_r <= 5'h00;
         keep_r <= 1'b0;
      end else if (clk_en) begin
         ok_r <= 1'b0;
         bad_r <= 1'b0;
         if (link.rdo_ready) begin
            got_r <= link.rdo_data;
            why_r <= why;
            ok_r <= (why == 5'h00);
            bad_r <= (why != 5'h00);
            keep_r <= link.rdo_data[PRB_NOSUS_BIT];
         end
      end
   end

   assign rdo_got = got_r;
   assign req_ok = ok_r;
   assign req_bad = bad_r;
   assign bad_why = why_r;
   assign keep_in_suspend = keep_r;
endmodule

// >>> verif/prb_monitor.sv
// Checker on the link between the sink end and the source end
`timescale 1ns/1ns
module prb_monitor
   import prb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic pdo_valid,
   input wire logic [PRB_W-1:0] pdo_data,
   input wire logic pdo_last,
   input wire logic rdo_valid,
   input wire logic [PRB_W-1:0] rdo_data,
   input wire logic rdo_ready,
   input wire logic goto_min
);
   // Field views of the request object on the wire
   wire logic [PRB_FW-1:0] op = rdo_data[PRB_OP_HI:PRB_OP_LO];
   wire logic [PRB_FW-1:0] lim = rdo_data[PRB_LIM_HI:PRB_LIM_LO];
   wire logic gb = rdo_data[PRB_GB_BIT];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Shape of every request object that goes out
   AST_RSV_ZERO: assert property (rdo_valid |->
      !rdo_data[PRB_RSV_HI] && rdo_data[PRB_RSV_LO_HI:PRB_RSV_LO_LO] == 4'h0)
      else $error("reserved bits set");
   AST_POS_NONZERO: assert property (rdo_valid |->
      rdo_data[PRB_POS_HI:PRB_POS_LO] != PRB_POS_NONE)
      else $error("position zero");
   AST_OP_LE_MAX: assert property (rdo_valid && !gb |->
      op <= lim) else $error("operating above maximum");
   AST_MIN_LE_OP: assert property (rdo_valid && gb |->
      lim <= op) else $error("minimum above operating");
   // Handshake: a new offer kills a stale request, one object per take
   AST_STALE_DROP: assert property (clk_en && rdo_valid
      && pdo_valid |=> !rdo_valid) else $error("request kept over new offer");
   AST_ONE_OBJ: assert property (clk_en && rdo_ready |=>
      !rdo_valid) else $error("request repeated after take");
   AST_LAST_IN_OFFER: assert property (pdo_last |->
      pdo_valid) else $error("last flag outside offer");
   // Bound keeps a lost answer visible; the bench never stalls clk_en
   // within four cycles of the end of an offer
   AST_ANSWER: assert property (clk_en && pdo_last |->
      ##[1:4] rdo_valid) else $error("no request after offer");

   // Main scenarios reached
   COV_GB: cover property (rdo_valid && gb);
   COV_MIS: cover property (rdo_valid && rdo_data[PRB_MIS_BIT]);
   COV_GOTO: cover property (goto_min);
   COV_DROP: cover property (rdo_valid && pdo_valid);
endmodule

// >>> verif/tb.sv
// Bench for both ends, plus a second source fed rogue requests
`timescale 1ns/1ns
module tb;
   import prb_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic tab_wr, send_caps, goto_min_req, need_changed, req_giveback;
   logic need_unmet, usb_comm_ok, no_usb_suspend;
   logic [PRB_PW-1:0] tab_idx, tab_count, req_pos;
   logic [PRB_W-1:0] tab_data, rdo_sent, rdo_got, rdo_got2;
   logic [PRB_FW-1:0] req_op, req_lim, min_load;
   logic req_battery, caps_held, busy, at_min, req_ok, req_bad;
   logic keep_in_suspend, req_ok2, req_bad2, keep2;
   logic [4:0] bad_why, bad_why2;
   logic [31:0] tab [7];
   int num_errors = 0;
   int n_checks = 0;
   int cnt, qp, qg, qo, ql, qu, qc, qs;

   prb_if l1();
   prb_if l2();
   // Sink and source facing each other on the main link
   prb_sink prb_sink_i (.mclk, .rst_n, .clk_en, .link(l1), .req_pos,
      .req_giveback, .req_op, .req_lim, .need_unmet, .usb_comm_ok,
      .no_usb_suspend, .need_changed, .rdo_sent, .req_battery,
      .caps_held, .busy, .at_min, .min_load);
   prb_source prb_source_i (.mclk, .rst_n, .clk_en, .link(l1), .tab_wr,
      .tab_idx, .tab_data, .tab_count, .send_caps, .goto_min_req,
      .rdo_got, .req_ok, .req_bad, .bad_why, .keep_in_suspend);
   // Second source: the bench stands in for a careless sink
   prb_source prb_source_i2 (.mclk, .rst_n, .clk_en, .link(l2), .tab_wr,
      .tab_idx, .tab_data, .tab_count, .send_caps, .goto_min_req(1'b0),
      .rdo_got(rdo_got2), .req_ok(req_ok2), .req_bad(req_bad2),
      .bad_why(bad_why2), .keep_in_suspend(keep2));
   prb_monitor prb_monitor_i (.mclk, .rst_n, .clk_en,
      .pdo_valid(l1.pdo_valid), .pdo_data(l1.pdo_data),
      .pdo_last(l1.pdo_last), .rdo_valid(l1.rdo_valid),
      .rdo_data(l1.rdo_data), .rdo_ready(l1.rdo_ready),
      .goto_min(l1.goto_min));

   // 20 MHz clock
   always #25 mclk = ~mclk;

   // Comparison and verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Reference builder: out-of-range position falls back to 1 with mismatch
   function automatic logic [31:0] exp_rdo();
      int p, f, o, l, m;
      p = qp;
      m = qu;
      if (p < 1 || p > cnt) begin
         p = 1;
         m = 1;
      end
      f = tab[p-1][9:0];
      if (qo > f) m = 1;
      o = qo > f ? f : qo;
      if (qg) l = ql < o ? ql : o;
      else l = ql > o ? ql : o;
      if (!qg && l > f) m = 1;
      return {1'b0, p[2:0], qg[0], m[0], qc[0], qs[0], 4'h0, o[9:0], l[9:0]};
   endfunction
   // Reference checker for a received object
   function automatic logic [4:0] exp_bad(input logic [31:0] w);
      int p, o, l, f;
      p = w[30:28];
      o = w[19:10];
      l = w[9:0];
      f = (p >= 1 && p <= cnt) ? tab[p-1][9:0] : 0;
      return {w[27] && l > o, !w[27] && ((!w[26] && l > f) || o > l),
         o > f, p == 0 || p > cnt, w[31] || w[23:20] != 4'h0};
   endfunction

   // Load a fresh random table and start an offer
   task automatic offer();
      cnt = $urandom_range(7, 1);
      for (int i = 0; i < 7; i++) begin
         tab[i] = $urandom;
         @(posedge mclk);
         tab_wr <= 1'b1;
         tab_idx <= i[2:0];
         tab_data <= tab[i];
      end
      @(posedge mclk);
      tab_wr <= 1'b0;
      tab_count <= cnt[2:0];
      send_caps <= 1'b1;
      @(posedge mclk);
      send_caps <= 1'b0;
   endtask
   // Random needs; position 0 and beyond the count are included
   task automatic setreq(input logic chg);
      qp = $urandom_range(7, 0);
      qg = $urandom_range(1, 0);
      qo = $urandom_range(1023, 0);
      ql = $urandom_range(1023, 0);
      qu = ($urandom_range(3, 0) == 0);
      qc = $urandom_range(1, 0);
      qs = $urandom_range(1, 0);
      @(posedge mclk);
      req_pos <= qp[2:0];
      req_giveback <= qg[0];
      req_op <= qo[9:0];
      req_lim <= ql[9:0];
      need_unmet <= qu[0];
      usb_comm_ok <= qc[0];
      no_usb_suspend <= qs[0];
      need_changed <= chg;
      @(posedge mclk);
      need_changed <= 1'b0;
   endtask
   // Wait for the source verdict, then compare against the model
   task automatic check_req();
      logic [31:0] e;
      int n;
      e = exp_rdo();
      for (n = 0; n < 20 && (req_ok | req_bad) !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      chk(req_ok, 1);
      chk({req_bad, bad_why}, 6'h00);
      chk(rdo_got, e);
      chk(rdo_sent, e);
      chk(caps_held, 1);
      chk(at_min, 0);
      chk(keep_in_suspend, qs);
      chk(req_battery, tab[e[30:28]-1][31:30] == 2'h1);
      @(posedge mclk);
      goto_min_req <= 1'b1;
      @(posedge mclk);
      goto_min_req <= 1'b0;
      #1;
      chk(at_min, qg);
      if (qg) chk(min_load, e[9:0]);
   endtask

   // Main sequence
   initial begin
      logic [31:0] w;
      void'($urandom(32'h4d7e61aa));
      {tab_wr, send_caps, goto_min_req, need_changed} = 4'h0;
      {tab_idx, tab_count, tab_data} = '0;
      {req_pos, req_giveback, req_op, req_lim} = '0;
      {need_unmet, usb_comm_ok, no_usb_suspend} = 3'h0;
      l2.rdo_valid = 1'b0;
      l2.rdo_data = 32'h0000_0000;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         setreq(1'b0);
         offer();
         check_req();
         setreq(1'b1);
         if (k % 2 == 0) begin
            // Stall: the fresh request must wait until clk_en returns
            clk_en <= 1'b0;
            repeat (3) @(posedge mclk);
            chk(busy, 0);
            clk_en <= 1'b1;
         end else begin
            // New offer of cnt objects lands on the request in flight and voids it when cnt is two to seven
            send_caps <= 1'b1;
            @(posedge mclk);
            send_caps <= 1'b0;
         end
         check_req();
      end
      $display("test build done");
      // Rogue objects: bad position carries zero fields
      for (int k = 0; k < 60; k++) begin
         w = $urandom;
         if (k % 2 == 0) w = w & 32'h7f0f_ffff;
         if (w[30:28] == 3'h0 || w[30:28] > cnt) w[19:0] = 20'h0_0000;
         @(posedge mclk);
         l2.rdo_valid <= 1'b1;
         l2.rdo_data <= w;
         do @(posedge mclk); while (l2.rdo_ready !== 1'b1);
         l2.rdo_valid <= 1'b0;
         // Verdict pulses stand only the cycle after the take
         #1;
         chk(bad_why2, exp_bad(w));
         chk(req_bad2, exp_bad(w) != 5'h0);
         chk(req_ok2, exp_bad(w) == 5'h0);
         chk(keep2, w[PRB_NOSUS_BIT]);
         chk(rdo_got2, w);
      end
      $display("test check done");
      close_out();
   end

   // Watchdog well past the expected run length
   initial begin
      #(50 * 40000);
      num_errors++;
      $display("BAD t=%0t watchdog expired", $time);
      close_out();
   end
endmodule
